// *** mic_defines.vh ***
`ifndef MIC_DEFINES_VH
`define MIC_DEFINES_VH
// printed offsets 0x0b and 0x1e are not word multiples: index * 4
`define MIC_IDX_CTRL0      8'h0b
`define MIC_IDX_CTRL1      8'h1e
`define MIC_IDX_USB_CTRL   8'h20
`define MIC_IDX_USB_REQ    8'h21
`define MIC_IDX_CORE       8'h40
`define MIC_ADDR_CTRL0     12'h02c
`define MIC_ADDR_CTRL1     12'h078
`define MIC_ADDR_USB_CTRL  12'h080
`define MIC_ADDR_USB_REQ   12'h084
`define MIC_ADDR_CORE      12'h100
// primary control bits
`define MIC_BIT_GIE        0
`define MIC_BIT_USB_EN     1
`define MIC_BIT_T0_EN      2
`define MIC_BIT_T1_EN      3
`define MIC_BIT_USB_PEND   4
`define MIC_BIT_T0_PEND    5
`define MIC_BIT_T1_PEND    6
// secondary control bits
`define MIC_BIT_PLAY_EN    0
`define MIC_BIT_SER_EN     1
`define MIC_BIT_CAP_EN     2
`define MIC_BIT_PLAY_PEND  4
`define MIC_BIT_SER_PEND   5
`define MIC_BIT_CAP_PEND   6
// usb control bits
`define MIC_BIT_SUSPEND    0
`define MIC_BIT_RESUME     3
// writable masks
`define MIC_MASK_CTRL      8'h7f
`define MIC_MASK_CTRL1     8'h77
`define MIC_MASK_USB_CTRL  8'h09
// reset values
`define MIC_RST_CTRL       8'h00
`define MIC_RST_USB        8'h00
// stack and vectors
`define MIC_STACK_DEPTH    5'h10
`define MIC_VEC_USB        12'h004
`define MIC_VEC_T0         12'h008
`define MIC_VEC_T1         12'h00c
`define MIC_VEC_PLAY       12'h010
`define MIC_VEC_SER        12'h014
`define MIC_VEC_CAP        12'h018
`endif

// *** mic_sync.v ***
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous event inputs
module mic_sync #(
    parameter W = 1
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // data
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    // first stage is read only by the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule // mic_sync

// *** mic_irq_ctrl.v ***
`timescale 1ns/10ps
`include "mic_defines.vh"
// Functional notes
// - primary bit 0 is global enable; clear masks all sources.
// - primary bits 1..3 enable usb, timer zero, timer one.
// - primary bits 4..6 are pending flags; bit 7 reads zero.
// - secondary bits 0..2 enable play, serial, capture; bits 3,7 zero.
// - secondary bits 4..6 are play, serial, capture pending flags.
// - acknowledge clears the global enable.
// - requests still set flags while global enable is clear.
// - software re-enabling inside service allows nesting.
// - no acknowledge while stack is full, until a return pops.
// - every source can wake the halted core.
// - acknowledge pushes only the program counter, branches to vector.
// - usb flag set by buffer access, suspend, resume or bus reset.
// - usb acknowledged vectors to 04h, clears usb flag and global enable.
// - buffer access sets its request bit; firmware clears it.
// - suspend sets usb control bit0, resume bit3; both raise usb.
// - timer zero overflow sets flag; vector 08h clears flag and enable.
// - fixed priority usb, t0, t1, play, serial, capture.
// - vectors t1 0ch, play 10h, serial 14h, capture 18h.
// - irq return restores pc and sets enable; plain return does not.
module mic_irq_ctrl (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // asynchronous event sources
    input  wire [7:0]  usb_buf_access,
    input  wire        usb_suspend,
    input  wire        usb_resume,
    input  wire        usb_bus_reset,
    input  wire        timer_zero_ovf,
    input  wire        timer_one_ovf,
    input  wire        play_data_valid,
    input  wire        serial_done,
    input  wire        capture_tick,
    // core handshake, same clock
    input  wire        core_can_take,
    input  wire        core_ret,
    input  wire        core_ret_irq,
    input  wire        core_call,
    input  wire        core_halted,
    output reg         irq_ack,
    output reg  [11:0] irq_vector,
    output reg         irq_push_pc,
    output reg         wake_req,
    output reg         stack_full
);
    // synchronised events and edge detection; event pins are levels from
    // other clock domains, so each passes two flops and only a rising
    // edge sets a flag: a level held high counts once
    wire [15:0] ev_s;
    reg  [15:0] ev_prev_q;
    wire [15:0] ev_rise;

    mic_sync #(
        .W(16)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({usb_buf_access, usb_suspend, usb_resume, usb_bus_reset,
                   timer_zero_ovf, timer_one_ovf, play_data_valid,
                   serial_done, capture_tick}),
        .dout    (ev_s)
    );

    // previous synchronised level; resets to the idle level of the pins
    // so that no false edge follows reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ev_prev_q <= 16'h0000;
        else
            ev_prev_q <= ev_s;
    end
    assign ev_rise = ev_s & ~ev_prev_q;

    wire [7:0] buf_ev     = ev_rise[15:8];
    wire       susp_ev    = ev_rise[7];
    wire       resume_ev  = ev_rise[6];
    wire       busrst_ev  = ev_rise[5];
    wire       t0_ev      = ev_rise[4];
    wire       t1_ev      = ev_rise[3];
    wire       play_ev    = ev_rise[2];
    wire       ser_ev     = ev_rise[1];
    wire       cap_ev     = ev_rise[0];
    wire       usb_ev     = (|buf_ev) | susp_ev | resume_ev | busrst_ev;

    // registers
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg [7:0] usb_ctrl_q;
    reg [7:0] usb_req_q;
    reg [4:0] sp_q;

    // apb decode
    wire acc     = psel & penable;
    wire wr      = acc & pwrite;
    wire hit_c0  = (paddr == `MIC_ADDR_CTRL0);
    wire hit_c1  = (paddr == `MIC_ADDR_CTRL1);
    wire hit_uc  = (paddr == `MIC_ADDR_USB_CTRL);
    wire hit_ur  = (paddr == `MIC_ADDR_USB_REQ);
    wire hit_co  = (paddr == `MIC_ADDR_CORE);
    wire mapped  = hit_c0 | hit_c1 | hit_uc | hit_ur | hit_co;
    wire wr_c0   = wr & hit_c0;
    wire wr_c1   = wr & hit_c1;
    wire wr_uc   = wr & hit_uc;
    wire wr_ur   = wr & hit_ur;

    // arbitration
    wire [5:0] pend = {ctrl1_q[`MIC_BIT_CAP_PEND] & ctrl1_q[`MIC_BIT_CAP_EN],
                       ctrl1_q[`MIC_BIT_SER_PEND] & ctrl1_q[`MIC_BIT_SER_EN],
                       ctrl1_q[`MIC_BIT_PLAY_PEND] & ctrl1_q[`MIC_BIT_PLAY_EN],
                       ctrl0_q[`MIC_BIT_T1_PEND] & ctrl0_q[`MIC_BIT_T1_EN],
                       ctrl0_q[`MIC_BIT_T0_PEND] & ctrl0_q[`MIC_BIT_T0_EN],
                       ctrl0_q[`MIC_BIT_USB_PEND] & ctrl0_q[`MIC_BIT_USB_EN]};
    wire       full_now = (sp_q == `MIC_STACK_DEPTH);
    // a request is taken when the global enable is set, an enabled flag
    // is pending, the stack has room and the core can branch; the cycle
    // after an acknowledge is skipped so each entry is a single pulse
    wire       gie_on   = ctrl0_q[`MIC_BIT_GIE];
    wire       any_pend = |pend;
    wire       room     = ~full_now;
    wire       take     = gie_on & any_pend & room &
                          core_can_take & ~irq_ack;
    reg  [5:0]  grant;
    reg  [11:0] vec_d;

    // fixed priority select
    always @* begin
        grant = 6'h00;
        vec_d = `MIC_VEC_USB;
        if (pend[0]) begin
            grant = 6'h01;
            vec_d = `MIC_VEC_USB;
        end else if (pend[1]) begin
            grant = 6'h02;
            vec_d = `MIC_VEC_T0;
        end else if (pend[2]) begin
            grant = 6'h04;
            vec_d = `MIC_VEC_T1;
        end else if (pend[3]) begin
            grant = 6'h08;
            vec_d = `MIC_VEC_PLAY;
        end else if (pend[4]) begin
            grant = 6'h10;
            vec_d = `MIC_VEC_SER;
        end else if (pend[5]) begin
            grant = 6'h20;
            vec_d = `MIC_VEC_CAP;
        end
    end
    // the granted flag is cleared only when its request is taken
    wire [5:0] clr = take ? grant : 6'h00;

    // primary and secondary control registers; set beats clear
    reg [7:0] c0_d;
    reg [7:0] c1_d;
    always @* begin
        c0_d = ctrl0_q;
        c1_d = ctrl1_q;
        if (wr_c0)
            c0_d = pwdata[7:0] & `MIC_MASK_CTRL;
        if (wr_c1)
            c1_d = pwdata[7:0] & `MIC_MASK_CTRL1;
        c0_d[`MIC_BIT_USB_PEND] = c0_d[`MIC_BIT_USB_PEND] & ~clr[0];
        c0_d[`MIC_BIT_T0_PEND]  = c0_d[`MIC_BIT_T0_PEND] & ~clr[1];
        c0_d[`MIC_BIT_T1_PEND]  = c0_d[`MIC_BIT_T1_PEND] & ~clr[2];
        c1_d[`MIC_BIT_PLAY_PEND] = c1_d[`MIC_BIT_PLAY_PEND] & ~clr[3];
        c1_d[`MIC_BIT_SER_PEND]  = c1_d[`MIC_BIT_SER_PEND] & ~clr[4];
        c1_d[`MIC_BIT_CAP_PEND]  = c1_d[`MIC_BIT_CAP_PEND] & ~clr[5];
        if (take)
            c0_d[`MIC_BIT_GIE] = 1'b0;
        if (core_ret_irq)
            c0_d[`MIC_BIT_GIE] = 1'b1;
        // flags set regardless of global enable
        if (usb_ev)
            c0_d[`MIC_BIT_USB_PEND] = 1'b1;
        if (t0_ev)
            c0_d[`MIC_BIT_T0_PEND] = 1'b1;
        if (t1_ev)
            c0_d[`MIC_BIT_T1_PEND] = 1'b1;
        if (play_ev)
            c1_d[`MIC_BIT_PLAY_PEND] = 1'b1;
        if (ser_ev)
            c1_d[`MIC_BIT_SER_PEND] = 1'b1;
        if (cap_ev)
            c1_d[`MIC_BIT_CAP_PEND] = 1'b1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q <= `MIC_RST_CTRL;
            ctrl1_q <= `MIC_RST_CTRL;
        end else begin
            ctrl0_q <= c0_d;
            ctrl1_q <= c1_d;
        end
    end

    // usb control and access request registers; events beat writes
    reg [7:0] usb_ctrl_d;
    reg [7:0] usb_req_d;
    always @* begin
        usb_ctrl_d = usb_ctrl_q;
        usb_req_d  = usb_req_q;
        if (wr_uc)
            usb_ctrl_d = pwdata[7:0] & `MIC_MASK_USB_CTRL;
        if (wr_ur)
            usb_req_d = pwdata[7:0];
        if (susp_ev)
            usb_ctrl_d[`MIC_BIT_SUSPEND] = 1'b1;
        if (resume_ev)
            usb_ctrl_d[`MIC_BIT_RESUME] = 1'b1;
        usb_req_d = usb_req_d | buf_ev;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_ctrl_q <= `MIC_RST_USB;
            usb_req_q  <= `MIC_RST_USB;
        end else begin
            usb_ctrl_q <= usb_ctrl_d;
            usb_req_q  <= usb_req_d;
        end
    end

    // stack depth tracking; a call and an acknowledge in one cycle push
    // twice, and a push onto a full stack is lost rather than counted
    wire       pop   = (core_ret | core_ret_irq) & (sp_q != 5'h00);
    wire [1:0] npush = {1'b0, core_call} + {1'b0, take};
    reg  [5:0] sp_sum;
    reg  [4:0] sp_d;
    always @* begin
        sp_sum = {1'b0, sp_q} + {4'h0, npush} - {5'h00, pop};
        sp_d   = sp_sum[4:0];
        if (sp_sum > {1'b0, `MIC_STACK_DEPTH})
            sp_d = `MIC_STACK_DEPTH;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            sp_q <= 5'h00;
        else
            sp_q <= sp_d;
    end

    // core outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack     <= 1'b0;
            irq_vector  <= 12'h000;
            irq_push_pc <= 1'b0;
            wake_req    <= 1'b0;
            stack_full  <= 1'b0;
        end else begin
            irq_ack     <= take;
            irq_push_pc <= take;
            if (take)
                irq_vector <= vec_d;
            // any raised flag wakes a halted core
            wake_req    <= core_halted & ((|c0_d[6:4]) | (|c1_d[6:4]));
            stack_full  <= full_now;
        end
    end

    // read mux; unused bits and unmapped offsets read zero
    reg [31:0] prdata_d;
    always @* begin
        prdata_d = 32'h00000000;
        if (hit_c0)
            prdata_d = {24'h000000, ctrl0_q};
        else if (hit_c1)
            prdata_d = {24'h000000, ctrl1_q};
        else if (hit_uc)
            prdata_d = {24'h000000, usb_ctrl_q};
        else if (hit_ur)
            prdata_d = {24'h000000, usb_req_q};
        else if (hit_co)
            prdata_d = {27'h0000000, sp_q};
    end

    // apb response: one wait-free cycle; read data are captured in the
    // setup cycle and stand through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= 32'h00000000;
            if (psel & ~penable & ~pwrite)
                prdata <= prdata_d;
        end
    end
endmodule // mic_irq_ctrl

// *** mic_irq_ctrl_checker.sv ***
`timescale 1ns/10ps
`include "mic_defines.vh"
// bus timing and acknowledge checks on the controller ports
module mic_irq_checker (
    // apb
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic        pslverr,
    // core side
    input logic        core_can_take,
    input logic        core_halted,
    input logic        irq_ack,
    input logic        irq_push_pc,
    input logic [11:0] irq_vector,
    input logic        wake_req,
    input logic        stack_full
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_with_ready: assert property (pslverr |-> pready && penable)
        else $error("pslverr outside access");
    chk_ack_push_pc: assert property (irq_ack |-> irq_push_pc)
        else $error("ack without push");
    chk_ack_spacing: assert property (irq_ack |=> !irq_ack)
        else $error("two acks in a row");
    chk_ack_after_take: assert property (irq_ack |-> $past(core_can_take))
        else $error("ack while core busy");
    chk_vector_table: assert property (irq_ack |-> irq_vector inside
        {`MIC_VEC_USB, `MIC_VEC_T0, `MIC_VEC_T1, `MIC_VEC_PLAY,
         `MIC_VEC_SER, `MIC_VEC_CAP}) else $error("bad vector");
    chk_full_blocks: assert property (stack_full ##1 stack_full |-> !irq_ack)
        else $error("ack with full stack");
    chk_wake_halted: assert property (wake_req |-> $past(core_halted))
        else $error("wake while running");
    // main scenarios
    cov_capture: cover property (irq_ack && irq_vector == `MIC_VEC_CAP);
    cov_full: cover property (stack_full ##1 stack_full);
    cov_err: cover property (pslverr);
endmodule // mic_irq_checker

bind mic_irq_ctrl mic_irq_checker i_chk (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pready        (pready),
    .pslverr       (pslverr),
    .core_can_take (core_can_take),
    .core_halted   (core_halted),
    .irq_ack       (irq_ack),
    .irq_push_pc   (irq_push_pc),
    .irq_vector    (irq_vector),
    .wake_req      (wake_req),
    .stack_full    (stack_full)
);

// *** mic_core_model.sv ***
`timescale 1ns/10ps
// core stand-in: takes acks, returns after a delay
module mic_core_model (
    // clock and reset
    input  logic pclk,
    input  logic presetn,
    // bench controls
    input  logic slow,
    input  logic hold,
    input  logic call_req,
    input  logic ret_req,
    // controller side
    input  logic irq_ack,
    output logic core_can_take,
    output logic core_ret,
    output logic core_ret_irq,
    output logic core_call
);
    logic [2:0] wait_q;
    logic       busy_q;
    // service routine timing; an ack under hold starts no routine, so no return follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {wait_q, busy_q, core_can_take} <= '0;
            {core_ret, core_ret_irq, core_call} <= '0;
        end else begin
            core_call <= call_req;
            core_ret <= ret_req;
            core_ret_irq <= 1'b0;
            core_can_take <= slow ? ~core_can_take : 1'b1;
            if (irq_ack && !hold) begin
                busy_q <= 1'b1;
                wait_q <= slow ? 3'h6 : 3'h1;
            end else if (busy_q && wait_q == 3'h0) begin
                busy_q <= 1'b0;
                core_ret_irq <= 1'b1;
            end else if (busy_q) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule // mic_core_model

// *** mic_irq_ctrl_tb.sv ***
`timescale 1ns/10ps
`include "mic_defines.vh"
module mic_irq_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
    logic [11:0] paddr, irq_vector, a;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  ubuf, w0, w1, e;
    logic [8:0]  ev;
    logic        halted, slow, hold, call, ret, take, cret, crti, ccall;
    logic        irq_ack, push, wake, full;
    int          err_count, comparisons, i, seed;
    logic [11:0] amap [5] = '{`MIC_ADDR_CTRL0, `MIC_ADDR_CTRL1,
        `MIC_ADDR_USB_CTRL, `MIC_ADDR_USB_REQ, `MIC_ADDR_CORE};
    mic_irq_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .usb_buf_access(ubuf),
        .usb_suspend(ev[7]), .usb_resume(ev[8]), .usb_bus_reset(ev[0]),
        .timer_zero_ovf(ev[1]), .timer_one_ovf(ev[2]),
        .play_data_valid(ev[3]), .serial_done(ev[4]), .capture_tick(ev[5]),
        .core_can_take(take), .core_ret(cret), .core_ret_irq(crti),
        .core_call(ccall), .core_halted(halted), .irq_ack, .irq_vector,
        .irq_push_pc(push), .wake_req(wake), .stack_full(full));
    mic_core_model i_core (.pclk, .presetn, .slow, .hold, .call_req(call),
        .ret_req(ret), .irq_ack, .core_can_take(take), .core_ret(cret),
        .core_ret_irq(crti), .core_call(ccall));
    // clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #60000;
        err_count++;
        conclude;
    end
    // one apb transfer; read data lands in r, error in sl
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
        if (pready !== 1'b1)
            err_count++;
        r = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [11:0] vec(input int s);
        return 12'(4 * s + 4);
    endfunction
    // wait for the next acknowledge and compare its vector
    task automatic wack(input int s);
        int n;
        n = 0;
        do @(posedge pclk); while (irq_ack !== 1'b1 && ++n < 60);
        chk({irq_ack, push, irq_vector}, {2'b11, vec(s)});
    endtask
    task automatic pulse(input logic [8:0] m, input logic [7:0] b);
        ev <= m;
        ubuf <= b;
        repeat (3) @(posedge pclk);
        ev <= '0;
        ubuf <= '0;
        repeat (4) @(posedge pclk);
    endtask
    // calls or plain returns from the core
    task automatic kick(input int n, input logic c);
        repeat (n) begin
            call <= c;
            ret <= !c;
            @(posedge pclk);
            {call, ret} <= 2'b00;
            @(posedge pclk);
        end
    endtask
    task automatic conclude;
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence
    initial begin
        seed = 32'hb59980bf;
        {presetn, psel, penable, pwrite, paddr, pwdata, ubuf, ev} = '0;
        {halted, slow, hold, call, ret} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 5; i++) begin
            apb(1'b0, amap[i], 8'h0);
            chk(r, 0);
        end
        apb(1'b0, 12'h010, 8'h0);
        chk({sl, r}, 33'h1_0000_0000);
        halted <= 1'b1;
        for (i = 0; i < 5; i++) begin
            w0 = i ? $random(seed) : 8'hff;
            w1 = i ? $random(seed) : 8'hff;
            apb(1'b1, `MIC_ADDR_CTRL0, w0 & 8'hfe);
            apb(1'b1, `MIC_ADDR_CTRL1, w1);
            apb(1'b0, `MIC_ADDR_CTRL0, 8'h0);
            chk(r, w0 & 8'h7e);
            apb(1'b0, `MIC_ADDR_CTRL1, 8'h0);
            chk(r, w1 & 8'h77);
            chk(wake, |((w0 | w1) & 8'h70));
        end
        halted <= 1'b0;
        hold <= 1'b1;
        apb(1'b1, `MIC_ADDR_CTRL1, 8'h0);
        for (i = 0; i < 6; i++) begin
            w0 = (i < 3) ? 8'h01 | 8'h02 << i : 8'h01;
            w1 = (i < 3) ? 8'h00 : 8'h01 << (i - 3);
            a = (i < 3) ? `MIC_ADDR_CTRL0 : `MIC_ADDR_CTRL1;
            e = (i < 3) ? w0 & 8'hfe : w1;
            apb(1'b1, `MIC_ADDR_CTRL1, w1);
            apb(1'b1, `MIC_ADDR_CTRL0, w0);
            ev <= 9'h1 << i;
            wack(i);
            ev <= '0;
            apb(1'b0, a, 8'h0);
            chk(r, e);
            pulse(9'h1 << i, 8'h0);
            apb(1'b0, a, 8'h0);
            chk(r, e | 8'h10 << i % 3);
            apb(1'b1, `MIC_ADDR_CTRL0, w0 | ((i < 3) ? 8'h10 << i : 8'h00));
            wack(i);
            kick(2, 1'b0);
            apb(1'b0, `MIC_ADDR_CTRL0, 8'h0);
            chk(r, w0 & 8'hfe);
        end
        apb(1'b1, `MIC_ADDR_CTRL0, 8'h0);
        w0 = 8'h01 << ({$random(seed)} % 8);
        pulse(9'h080, w0);
        apb(1'b0, `MIC_ADDR_USB_CTRL, 8'h0);
        chk(r, 8'h01);
        pulse(9'h100, 8'h0);
        apb(1'b0, `MIC_ADDR_USB_CTRL, 8'h0);
        chk(r, 8'h09);
        apb(1'b0, `MIC_ADDR_USB_REQ, 8'h0);
        chk(r, w0);
        apb(1'b0, `MIC_ADDR_CTRL0, 8'h0);
        chk(r, 8'h10);
        apb(1'b1, `MIC_ADDR_USB_REQ, 8'h0);
        apb(1'b1, `MIC_ADDR_USB_CTRL, 8'h0);
        apb(1'b1, `MIC_ADDR_CTRL0, 8'h0);
        hold <= 1'b0;
        slow <= 1'b1;
        apb(1'b1, `MIC_ADDR_CTRL1, 8'h07);
        apb(1'b1, `MIC_ADDR_CTRL0, 8'h0e);
        pulse(9'h03f, 8'h0);
        apb(1'b1, `MIC_ADDR_CTRL0, 8'h7f);
        for (i = 0; i < 6; i++) wack(i);
        repeat (12) @(posedge pclk);
        slow <= 1'b0;
        hold <= 1'b1;
        kick(16, 1'b1);
        apb(1'b0, `MIC_ADDR_CORE, 8'h0);
        chk({full, r}, {1'b1, 32'h10});
        apb(1'b1, `MIC_ADDR_CTRL0, 8'h05);
        pulse(9'h002, 8'h0);
        apb(1'b0, `MIC_ADDR_CTRL0, 8'h0);
        chk(r, 8'h25);
        kick(1, 1'b0);
        wack(1);
        conclude;
    end
endmodule // mic_irq_ctrl_tb
